// ==== core/nav_sentence_formatter.sv ====
// Purpose: emits satellite-status and motion text sentences as a byte stream
// Assumes: nav inputs and tx_ready come from logic on the same clock
// Notes:   fields are read live from registers while a sentence is sent
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module nav_sentence_formatter
#(
	parameter logic [63:0] RATE_CYCLES  = nav_fmt_pkg::RATE_CYCLES,
	parameter logic [63:0] TRAIN_CYCLES = nav_fmt_pkg::TRAIN_CYCLES
)
(
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire nav_fmt_pkg::apb_req_s apb_in,
	output nav_fmt_pkg::apb_rsp_s      apb_out,
	input  wire logic                  tx_ready,
	output nav_fmt_pkg::tx_s           tx_out,
	input  wire logic                  angle_strap,
	input  wire logic                  angle_found,
	input  wire logic                  driving,
	output logic [1:0]                 sol_status
);
	nav_fmt_pkg::fmt_state_s s;
	nav_fmt_pkg::fmt_state_s next_s;
	nav_fmt_pkg::gen_s       g;
	logic                    cs_en;
	logic [7:0]              cs_sum;
	logic                    rate_tick;
	logic                    train_tick;
	logic [4:0]              tail_seg;
	logic [3:0]              slot;
	logic [7:0]              sv_id;
	logic [20:0]             gated;
	logic                    setup;
	logic                    wr;
	logic                    legal;
	logic [31:0]             rd;

	function automatic logic [7:0] dg(input logic [3:0] b);
		return nav_fmt_pkg::CH_ZERO + {4'h0, b};
	endfunction

	function automatic logic [7:0] hx(input logic [3:0] b);
		return (b < 4'hA) ? dg(b) : nav_fmt_pkg::CH_HEXA + {4'h0, b};
	endfunction

	function automatic nav_fmt_pkg::gen_s lit2(input logic [7:0] c, input logic [3:0] pos);
		nav_fmt_pkg::gen_s r;
		r.ch = (pos == 4'h0) ? c : nav_fmt_pkg::CH_COMMA;
		r.skip = 1'b0;
		r.last = (pos != 4'h0);
		return r;
	endfunction

	function automatic nav_fmt_pkg::gen_s hdr(input logic [55:0] h, input logic [3:0] pos);
		nav_fmt_pkg::gen_s r;
		r.ch = 8'(h >> (8 * (6 - 32'(pos))));
		r.skip = 1'b0;
		r.last = (pos == 4'h6);
		return r;
	endfunction

	// sign, up to three integer digits with zero suppression, two decimals
	function automatic nav_fmt_pkg::gen_s num(input logic [20:0] v, input logic [3:0] pos,
		input logic comma);
		nav_fmt_pkg::gen_s r;
		r = '{last: 1'b0, skip: 1'b0, ch: nav_fmt_pkg::CH_COMMA};
		case (pos)
			4'h0:
			begin
				r.ch = nav_fmt_pkg::CH_MINUS;
				r.skip = !v[20];
			end
			4'h1:
			begin
				r.ch = dg(v[19:16]);
				r.skip = (v[19:16] == 4'h0);
			end
			4'h2:
			begin
				r.ch = dg(v[15:12]);
				r.skip = (v[19:12] == 8'h00);
			end
			4'h3: r.ch = dg(v[11:8]);
			4'h4: r.ch = nav_fmt_pkg::CH_DOT;
			4'h5: r.ch = dg(v[7:4]);
			4'h6:
			begin
				r.ch = dg(v[3:0]);
				r.last = !comma;
			end
			default: r.last = 1'b1;
		endcase
		return r;
	endfunction

	function automatic nav_fmt_pkg::gen_s tail(input logic [3:0] pos, input logic [7:0] sum);
		nav_fmt_pkg::gen_s r;
		r = '{last: 1'b0, skip: 1'b0, ch: nav_fmt_pkg::CH_STAR};
		case (pos)
			4'h1: r.ch = hx(sum[7:4]);
			4'h2: r.ch = hx(sum[3:0]);
			4'h3: r.ch = nav_fmt_pkg::CH_CR;
			4'h4:
			begin
				r.ch = nav_fmt_pkg::CH_LF;
				r.last = 1'b1;
			end
			default: r.ch = nav_fmt_pkg::CH_STAR;
		endcase
		return r;
	endfunction

	nav_checksum u_checksum
	(
		.clock (clock),
		.rstn  (rstn),
		.clear (s.fsm == nav_fmt_pkg::FSM_IDLE),
		.en    (cs_en),
		.data  (g.ch),
		.sum   (cs_sum)
	);

	nav_period_timer #(.W(nav_fmt_pkg::RATE_W), .COUNT(RATE_CYCLES)) u_rate
	(
		.clock (clock),
		.rstn  (rstn),
		.run   (s.speed_en),
		.clear (!s.speed_en),
		.tick  (rate_tick)
	);

	nav_period_timer #(.W(nav_fmt_pkg::TRAIN_W), .COUNT(TRAIN_CYCLES)) u_train
	(
		.clock (clock),
		.rstn  (rstn),
		.run   (driving && s.sol == nav_fmt_pkg::SOL_CONVERGE),
		.clear (s.sol != nav_fmt_pkg::SOL_CONVERGE),
		.tick  (train_tick)
	);

	// character generator for the current segment and position
	always_comb
	begin
		tail_seg = s.spd ? nav_fmt_pkg::SEG_TAIL_SPD : nav_fmt_pkg::SEG_TAIL_GSA;
		slot = 4'(s.seg - 5'h03);
		sv_id = s.sv_ids[8 * slot +: 8];
		gated = 21'h0;
		g = '{last: 1'b1, skip: 1'b0, ch: nav_fmt_pkg::CH_COMMA};
		if (s.seg == tail_seg)
			g = tail(s.pos, cs_sum);
		else if (!s.spd)
		begin
			if (s.seg == 5'h00)
				g = hdr(nav_fmt_pkg::GSA_HDR, s.pos);
			else if (s.seg == 5'h01)
				g = lit2(s.manual ? nav_fmt_pkg::CH_M : nav_fmt_pkg::CH_A, s.pos);
			else if (s.seg == 5'h02)
				g = lit2(dg({2'b00, (s.fix == 2'h3) ? 2'h3 : s.fix + 2'h1}), s.pos);
			else if (s.seg <= 5'h0E)
			begin
				g.ch = (s.pos == 4'h0) ? dg(sv_id[7:4]) : dg(sv_id[3:0]);
				g.skip = !s.sv_mask[slot] && s.pos != 4'h2;
				g.last = (s.pos == 4'h2);
				if (s.pos == 4'h2)
					g.ch = nav_fmt_pkg::CH_COMMA;
			end
			else if (s.seg == 5'h0F)
				g = num({5'h00, s.pdop}, s.pos, 1'b1);
			else if (s.seg == 5'h10)
				g = num({5'h00, s.hdop}, s.pos, 1'b1);
			else
				g = num({5'h00, s.vdop}, s.pos, 1'b0);
		end
		else
		begin
			// angle not known yet: sensor axes cannot be rotated, report zero
			case (s.seg)
				5'h05: gated = s.acc_x;
				5'h06: gated = s.acc_y;
				5'h07: gated = s.acc_z;
				default: gated = s.yaw;
			endcase
			if (s.sol == nav_fmt_pkg::SOL_INVALID)
				gated = 21'h0;
			case (s.seg)
				5'h00: g = hdr(nav_fmt_pkg::SPD_HDR, s.pos);
				5'h01:
				begin
					g.last = (s.pos == 4'h9);
					g.ch = dg(4'(s.utc >> (28 - 4 * ((s.pos > 4'h6) ? 32'(s.pos) - 1 : 32'(s.pos)))));
					if (s.pos == 4'h6)
						g.ch = nav_fmt_pkg::CH_DOT;
					if (s.pos == 4'h9)
						g.ch = nav_fmt_pkg::CH_COMMA;
				end
				5'h02: g = num({5'h00, s.speed}, s.pos, 1'b1);
				5'h03: g = lit2(dg({2'b00, s.sol}), s.pos);
				5'h04: g = lit2(nav_fmt_pkg::CH_A, s.pos);
				5'h08: g = lit2(nav_fmt_pkg::CH_G, s.pos);
				5'h0A: g = lit2(nav_fmt_pkg::CH_S, s.pos);
				5'h0B: g = lit2(dg(s.flags[23:20]), s.pos);
				5'h0C: g = lit2(dg(s.flags[19:16]), s.pos);
				5'h0D:
				begin
					g.last = (s.pos == 4'h4);
					g.ch = dg(4'(s.flags[15:0] >> (12 - 4 * ((s.pos > 4'h1) ? 32'(s.pos) - 1 : 0))));
					if (s.pos == 4'h1)
						g.ch = nav_fmt_pkg::CH_DOT;
				end
				5'h09: g = num(gated, s.pos, 1'b1);
				default: g = num(gated, s.pos, 1'b1);
			endcase
		end
	end

	// apb decode: zero wait state, answered one cycle after setup
	always_comb
	begin
		setup = apb_in.psel && !apb_in.penable;
		wr = apb_in.psel && apb_in.penable && s.rsp.pready && apb_in.pwrite && !s.rsp.pslverr;
		legal = (apb_in.paddr[1:0] == 2'b00) && (apb_in.paddr <= nav_fmt_pkg::OFF_FLAGS);
		case (apb_in.paddr)
			nav_fmt_pkg::OFF_CTRL:    rd = {29'h0, s.speed_en, s.manual, 1'b0};
			nav_fmt_pkg::OFF_STATUS:  rd = {29'h0, s.fsm != nav_fmt_pkg::FSM_IDLE, s.sol};
			nav_fmt_pkg::OFF_FIX:     rd = {30'h0, s.fix};
			nav_fmt_pkg::OFF_SV_MASK: rd = {20'h0, s.sv_mask};
			nav_fmt_pkg::OFF_SV0:     rd = s.sv_ids[31:0];
			nav_fmt_pkg::OFF_SV1:     rd = s.sv_ids[63:32];
			nav_fmt_pkg::OFF_SV2:     rd = s.sv_ids[95:64];
			nav_fmt_pkg::OFF_DOP_PH:  rd = {s.hdop, s.pdop};
			nav_fmt_pkg::OFF_DOP_V:   rd = {16'h0, s.vdop};
			nav_fmt_pkg::OFF_UTC:     rd = s.utc;
			nav_fmt_pkg::OFF_SPEED:   rd = {16'h0, s.speed};
			nav_fmt_pkg::OFF_ACC_X:   rd = {s.acc_x[20], 11'h0, s.acc_x[19:0]};
			nav_fmt_pkg::OFF_ACC_Y:   rd = {s.acc_y[20], 11'h0, s.acc_y[19:0]};
			nav_fmt_pkg::OFF_ACC_Z:   rd = {s.acc_z[20], 11'h0, s.acc_z[19:0]};
			nav_fmt_pkg::OFF_YAW:     rd = {s.yaw[20], 11'h0, s.yaw[19:0]};
			nav_fmt_pkg::OFF_FLAGS:   rd = {8'h0, s.flags};
			default:                  rd = nav_fmt_pkg::REG_RST;
		endcase
	end

	always_comb
	begin
		next_s = s;
		cs_en = 1'b0;
		next_s.rsp.pready = setup;
		if (setup)
		begin
			next_s.rsp.prdata = legal ? rd : nav_fmt_pkg::REG_RST;
			next_s.rsp.pslverr = !legal;
		end
		// strap is caught on the first clocked cycle after reset release
		if (!s.started)
		begin
			next_s.started = 1'b1;
			next_s.sol = angle_strap ? nav_fmt_pkg::SOL_CONVERGE : nav_fmt_pkg::SOL_INVALID;
		end
		else if (s.sol == nav_fmt_pkg::SOL_INVALID && angle_found)
			next_s.sol = nav_fmt_pkg::SOL_CONVERGE;
		else if (s.sol == nav_fmt_pkg::SOL_CONVERGE && train_tick)
			next_s.sol = nav_fmt_pkg::SOL_VALID;
		unique case (s.fsm)
			nav_fmt_pkg::FSM_IDLE:
			begin
				// motion sentence first so its fixed rate is kept
				if (s.spd_pend || s.gsa_pend)
				begin
					next_s.spd = s.spd_pend;
					if (s.spd_pend)
						next_s.spd_pend = 1'b0;
					else
						next_s.gsa_pend = 1'b0;
					next_s.seg = 5'h00;
					next_s.pos = 4'h0;
					next_s.fin = 1'b0;
					next_s.fsm = nav_fmt_pkg::FSM_GEN;
				end
			end
			nav_fmt_pkg::FSM_GEN:
			begin
				if (!g.skip)
				begin
					next_s.tx.data = g.ch;
					next_s.tx.valid = 1'b1;
					next_s.fsm = nav_fmt_pkg::FSM_WAIT;
					cs_en = (s.seg != tail_seg) && !(s.seg == 5'h00 && s.pos == 4'h0);
				end
				if (g.last && s.seg == tail_seg)
					next_s.fin = 1'b1;
				else if (g.last)
				begin
					next_s.seg = s.seg + 5'h01;
					next_s.pos = 4'h0;
				end
				else
					next_s.pos = s.pos + 4'h1;
			end
			nav_fmt_pkg::FSM_WAIT:
			begin
				if (tx_ready)
				begin
					next_s.tx.valid = 1'b0;
					next_s.fsm = s.fin ? nav_fmt_pkg::FSM_IDLE : nav_fmt_pkg::FSM_GEN;
				end
			end
			default: next_s.fsm = nav_fmt_pkg::FSM_IDLE;
		endcase
		// set wins over the clear taken above
		if (rate_tick)
			next_s.spd_pend = 1'b1;
		if (wr)
		begin
			case (apb_in.paddr)
				nav_fmt_pkg::OFF_CTRL:
				begin
					if (apb_in.pwdata[nav_fmt_pkg::CTRL_GSA_GO])
						next_s.gsa_pend = 1'b1;
					next_s.manual = apb_in.pwdata[nav_fmt_pkg::CTRL_MANUAL];
					next_s.speed_en = apb_in.pwdata[nav_fmt_pkg::CTRL_SPEED_EN];
				end
				nav_fmt_pkg::OFF_FIX:     next_s.fix = apb_in.pwdata[1:0];
				nav_fmt_pkg::OFF_SV_MASK: next_s.sv_mask = apb_in.pwdata[11:0];
				nav_fmt_pkg::OFF_SV0:     next_s.sv_ids[31:0] = apb_in.pwdata;
				nav_fmt_pkg::OFF_SV1:     next_s.sv_ids[63:32] = apb_in.pwdata;
				nav_fmt_pkg::OFF_SV2:     next_s.sv_ids[95:64] = apb_in.pwdata;
				nav_fmt_pkg::OFF_DOP_PH:  {next_s.hdop, next_s.pdop} = apb_in.pwdata;
				nav_fmt_pkg::OFF_DOP_V:   next_s.vdop = apb_in.pwdata[15:0];
				nav_fmt_pkg::OFF_UTC:     next_s.utc = apb_in.pwdata;
				nav_fmt_pkg::OFF_SPEED:   next_s.speed = apb_in.pwdata[15:0];
				nav_fmt_pkg::OFF_ACC_X:   next_s.acc_x = {apb_in.pwdata[31], apb_in.pwdata[19:0]};
				nav_fmt_pkg::OFF_ACC_Y:   next_s.acc_y = {apb_in.pwdata[31], apb_in.pwdata[19:0]};
				nav_fmt_pkg::OFF_ACC_Z:   next_s.acc_z = {apb_in.pwdata[31], apb_in.pwdata[19:0]};
				nav_fmt_pkg::OFF_YAW:     next_s.yaw = {apb_in.pwdata[31], apb_in.pwdata[19:0]};
				nav_fmt_pkg::OFF_FLAGS:   next_s.flags = apb_in.pwdata[23:0];
				default:                  next_s.flags = s.flags;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign apb_out = s.rsp;
	assign tx_out = s.tx;
	assign sol_status = s.sol;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	logic gen_now;
	assign gen_now = s.fsm == nav_fmt_pkg::FSM_GEN;

	a_gsa_header_dollar: assert property (gen_now && !s.spd && s.seg == 5'h00 && s.pos == 4'h0
		|=> tx_out.valid && tx_out.data == 8'h24) else $error("status sentence lacks leading dollar");
	a_mode_letter: assert property (gen_now && !s.spd && s.seg == 5'h01 && s.pos == 4'h0
		|=> tx_out.data == ($past(s.manual) ? 8'h4D : 8'h41)) else $error("wrong mode letter");
	a_fix_code: assert property (gen_now && !s.spd && s.seg == 5'h02 && s.pos == 4'h0 && s.fix == 2'h0
		|=> tx_out.data == 8'h31) else $error("no-fix code not 1");
	a_empty_slot: assert property (gen_now && !s.spd && s.seg inside {[5'h03:5'h0E]}
		&& !s.sv_mask[slot] && s.pos == 4'h0 |=> !tx_out.valid) else $error("empty slot emitted digit");
	a_lf_after_cr: assert property (tx_out.valid && tx_ready && tx_out.data == 8'h0D
		|-> ##[2:3] (tx_out.valid && tx_out.data == 8'h0A)) else $error("CR not followed by LF");
	a_utc_dot: assert property (gen_now && s.spd && s.seg == 5'h01 && s.pos == 4'h6
		|=> tx_out.data == 8'h2E) else $error("time decimal point missing");
	a_speed_sep_g: assert property (gen_now && s.spd && s.seg == 5'h08 && s.pos == 4'h0
		|=> tx_out.data == 8'h47) else $error("G separator missing");
	a_rate_pend: assert property (rate_tick |=> s.spd_pend || $past(s.fsm) == nav_fmt_pkg::FSM_IDLE)
		else $error("rate tick lost");
	a_status_no_jump: assert property (s.sol == 2'h0 |=> s.sol != 2'h2)
		else $error("status skipped converging");
	a_status_train: assert property (s.started && s.sol == 2'h1 && train_tick |=> s.sol == 2'h2)
		else $error("training end not reported");
	a_accel_gated: assert property (gen_now && s.spd && s.seg == 5'h05 && s.pos == 4'h3
		&& s.sol == 2'h0 |=> tx_out.data == 8'h30) else $error("accel shown before angle known");
	a_yaw_sign: assert property (gen_now && s.spd && s.seg == 5'h09 && s.pos == 4'h0 && s.yaw[20]
		&& s.sol != 2'h0 |=> tx_out.data == 8'h2D) else $error("yaw sign missing");

	c_gsa_done: cover property (tx_out.valid && tx_ready && tx_out.data == 8'h0A && !s.spd);
	c_speed_done: cover property (tx_out.valid && tx_ready && tx_out.data == 8'h0A && s.spd);
	c_status_valid: cover property (s.sol == 2'h1 ##1 s.sol == 2'h2);
	c_tx_stall: cover property (tx_out.valid && !tx_ready [*3]);
endmodule // nav_sentence_formatter

// ==== core/nav_fmt_pkg.sv ====
// Purpose: shared constants and carriers for the navigation sentence formatter
// Assumes: 200 MHz clock, APB with 8-bit byte address and 32-bit data
// Notes:   numeric fields are held in BCD, sign in bit 20 of signed fields
package nav_fmt_pkg;

	localparam logic [63:0] CLK_HZ         = 64'h0BEBC200;
	localparam logic [63:0] RATE_HZ        = 64'hA;
	localparam logic [63:0] RATE_CYCLES    = CLK_HZ / RATE_HZ;
	localparam logic [63:0] TRAIN_TIME_MIN = 64'h3;
	localparam logic [63:0] TRAIN_CYCLES   = TRAIN_TIME_MIN * 64'h3C * CLK_HZ;
	localparam int unsigned RATE_W         = 25;
	localparam int unsigned TRAIN_W        = 36;

	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_FIX     = 8'h08;
	localparam logic [7:0] OFF_SV_MASK = 8'h0C;
	localparam logic [7:0] OFF_SV0     = 8'h10;
	localparam logic [7:0] OFF_SV1     = 8'h14;
	localparam logic [7:0] OFF_SV2     = 8'h18;
	localparam logic [7:0] OFF_DOP_PH  = 8'h1C;
	localparam logic [7:0] OFF_DOP_V   = 8'h20;
	localparam logic [7:0] OFF_UTC     = 8'h24;
	localparam logic [7:0] OFF_SPEED   = 8'h28;
	localparam logic [7:0] OFF_ACC_X   = 8'h2C;
	localparam logic [7:0] OFF_ACC_Y   = 8'h30;
	localparam logic [7:0] OFF_ACC_Z   = 8'h34;
	localparam logic [7:0] OFF_YAW     = 8'h38;
	localparam logic [7:0] OFF_FLAGS   = 8'h3C;

	localparam int unsigned CTRL_GSA_GO   = 0;
	localparam int unsigned CTRL_MANUAL   = 1;
	localparam int unsigned CTRL_SPEED_EN = 2;
	localparam int unsigned STAT_BUSY     = 2;
	localparam logic [31:0] REG_RST       = 32'h0;
	localparam logic [1:0]  SOL_INVALID   = 2'h0;
	localparam logic [1:0]  SOL_CONVERGE  = 2'h1;
	localparam logic [1:0]  SOL_VALID     = 2'h2;

	localparam logic [7:0]  CH_COMMA = 8'h2C;
	localparam logic [7:0]  CH_DOT   = 8'h2E;
	localparam logic [7:0]  CH_MINUS = 8'h2D;
	localparam logic [7:0]  CH_STAR  = 8'h2A;
	localparam logic [7:0]  CH_CR    = 8'h0D;
	localparam logic [7:0]  CH_LF    = 8'h0A;
	localparam logic [7:0]  CH_ZERO  = 8'h30;
	localparam logic [7:0]  CH_HEXA  = 8'h37;
	localparam logic [7:0]  CH_M     = 8'h4D;
	localparam logic [7:0]  CH_A     = 8'h41;
	localparam logic [7:0]  CH_G     = 8'h47;
	localparam logic [7:0]  CH_S     = 8'h53;
	localparam logic [55:0] GSA_HDR  = 56'h24474E4753412C;
	localparam logic [55:0] SPD_HDR  = 56'h2453504545442C;
	localparam logic [4:0]  SEG_TAIL_GSA = 5'h12;
	localparam logic [4:0]  SEG_TAIL_SPD = 5'h0E;

	typedef enum logic [1:0] {FSM_IDLE = 2'b00, FSM_GEN = 2'b01, FSM_WAIT = 2'b10} fsm_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} tx_s;

	typedef struct packed {
		logic       last;
		logic       skip;
		logic [7:0] ch;
	} gen_s;

	typedef struct packed {
		logic [7:0] sum;
	} cs_state_s;

	typedef struct packed {
		fsm_e        fsm;
		logic        spd;
		logic        fin;
		logic [4:0]  seg;
		logic [3:0]  pos;
		tx_s         tx;
		logic        gsa_pend;
		logic        spd_pend;
		logic        started;
		logic [1:0]  sol;
		logic        manual;
		logic        speed_en;
		logic [1:0]  fix;
		logic [11:0] sv_mask;
		logic [95:0] sv_ids;
		logic [15:0] pdop;
		logic [15:0] hdop;
		logic [15:0] vdop;
		logic [31:0] utc;
		logic [15:0] speed;
		logic [20:0] acc_x;
		logic [20:0] acc_y;
		logic [20:0] acc_z;
		logic [20:0] yaw;
		logic [23:0] flags;
		apb_rsp_s    rsp;
	} fmt_state_s;

endpackage

// ==== core/nav_checksum.sv ====
// Purpose: running xor checksum over the characters of one sentence
// Assumes: clear and en never both high in one cycle
// Notes:   sum is the xor of every byte accepted since the last clear
`timescale 1ns/1ps
module nav_checksum
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       clear,
	input  wire logic       en,
	input  wire logic [7:0] data,
	output logic      [7:0] sum
);
	nav_fmt_pkg::cs_state_s s;
	nav_fmt_pkg::cs_state_s next_s;

	always_comb
	begin
		next_s = s;
		if (clear)
			next_s.sum = 8'h00;
		else if (en)
			next_s.sum = s.sum ^ data;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign sum = s.sum;
endmodule // nav_checksum

// ==== core/nav_period_timer.sv ====
// Purpose: counts cycles while run is high and pulses tick every COUNT cycles
// Assumes: COUNT at least 1 and below two to the W
// Notes:   clear restarts the count; tick is registered
`timescale 1ns/1ps
module nav_period_timer
#(
	parameter int unsigned W     = 25,
	parameter logic [63:0] COUNT = 64'h1
)
(
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic run,
	input  wire logic clear,
	output logic      tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} tmr_state_s;

	tmr_state_s s;
	tmr_state_s next_s;

	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (clear)
			next_s.cnt = '0;
		else if (run)
		begin
			if (s.cnt == W'(COUNT - 64'h1))
			begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
			end
			else
				next_s.cnt = s.cnt + W'(1);
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;
endmodule // nav_period_timer

// ==== tb/nav_host_sink.sv ====
// Purpose: host-side byte sink that drives tx_ready for the sentence stream
// Assumes: same clock as the formatter
// Notes:   slow 0 always ready, 3 stalls three cycles in four
`timescale 1ns/1ps
module nav_host_sink
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [1:0] slow,
	output logic            tx_ready
);
	logic [31:0] seed;
	function automatic logic [31:0] xs(logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			seed     <= 32'hB08BEF92;
			tx_ready <= 1'b0;
		end
		else
		begin
			seed     <= xs(seed);
			tx_ready <= seed[1:0] >= slow;
		end
	end
endmodule // nav_host_sink

// ==== tb/nav_sentence_formatter_test.sv ====
// Purpose: self-checking bench for the sentence formatter
// Assumes: shortened rate and training counts
// Notes:   sentences are rebuilt here from the register values written
`timescale 1ns/1ps
module nav_sentence_formatter_test;
	localparam int RATE  = 600;
	localparam int TRAIN = 200;
	logic                  clock = 0;
	logic                  rstn  = 0;
	nav_fmt_pkg::apb_req_s req   = '0;
	nav_fmt_pkg::apb_rsp_s rsp;
	nav_fmt_pkg::tx_s      tx;
	logic                  tx_ready;
	logic                  strap = 0;
	logic                  found = 0;
	logic                  drv   = 0;
	logic                  pv    = 0;
	logic                  err;
	logic [1:0]            slow  = 0;
	logic [1:0]            sol;
	logic [31:0]           seed  = 32'hB08BEF92;
	logic [31:0]           rdata;
	int                    n_errors = 0;
	int                    checks_done = 0;
	int                    cyc = 0;
	string                 cur = "";
	string                 got;
	string                 lines[$];
	int                    starts[$];

	always #2.5 clock = ~clock;

	nav_sentence_formatter #(.RATE_CYCLES(64'h258), .TRAIN_CYCLES(64'hC8)) nav_sentence_formatter_i
		(.clock(clock), .rstn(rstn), .apb_in(req), .apb_out(rsp), .tx_ready(tx_ready),
		.tx_out(tx), .angle_strap(strap), .angle_found(found), .driving(drv), .sol_status(sol));
	nav_host_sink nav_host_sink_i (.clock(clock), .rstn(rstn), .slow(slow), .tx_ready(tx_ready));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] bcd();
		logic [31:0] v;
		for (int i = 0; i < 8; i++)
			v[4*i+:4] = 4'(rnd() % 10);
		return v;
	endfunction
	// leading zeros dropped, at least one integer digit kept
	function automatic string num(logic [19:0] v, int nd);
		string s = "";
		for (int i = nd + 1; i >= 2; i--)
			if (s != "" || v[4*i+:4] != 0 || i == 2)
				s = {s, $sformatf("%0h", v[4*i+:4])};
		return {s, $sformatf(".%02h", v[7:0])};
	endfunction
	function automatic string hx(logic [3:0] n);
		return $sformatf("%c", n < 10 ? 8'h30 + n : 8'h37 + n);
	endfunction
	function automatic string seal(string s);
		logic [7:0] x = 0;
		for (int i = 1; i < s.len(); i++)
			x ^= s[i];
		return {s, "*", hx(x[7:4]), hx(x[3:0]), "\r\n"};
	endfunction
	function automatic string sg(logic [31:0] v, logic [1:0] st);
		string m = "";
		if (st == 0)
			return "0.00";
		if (v[31])
			m = "-";
		return {m, num(v[19:0], 3)};
	endfunction
	function automatic string gsa(logic md, logic [1:0] fx, logic [11:0] m, logic [95:0] id,
		logic [31:0] ph, logic [15:0] v);
		string s;
		s = $sformatf("$GNGSA,%s,%0d,", md ? "M" : "A", fx == 0 ? 1 : fx == 1 ? 2 : 3);
		for (int i = 0; i < 12; i++)
		begin
			if (m[i])
				s = {s, $sformatf("%02h", id[8*i+:8])};
			s = {s, ","};
		end
		return seal({s, num(ph[15:0], 2), ",", num(ph[31:16], 2), ",", num(v, 2)});
	endfunction
	function automatic string spd(logic [31:0] u, logic [15:0] sp, logic [1:0] st,
		logic [31:0] a [4], logic [23:0] f);
		string s;
		s = $sformatf("$SPEED,%06h.%02h,%s,%0d,A,", u[31:8], u[7:0], num(sp, 2), st);
		s = {s, sg(a[0], st), ",", sg(a[1], st), ",", sg(a[2], st), ",G,", sg(a[3], st), ",S,"};
		return seal({s, $sformatf("%0h,%0h,%0h.%03h", f[23:20], f[19:16], f[15:12], f[11:0])});
	endfunction

	task automatic check(bit ok, string msg);
		checks_done++;
		if (!ok)
		begin
			n_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k = 0;
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 20);
		check(k < 20, "no pready");
		// answer taken at the edge that sees pready, request released there
		rdata = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic getline(output string s);
		int k = 0;
		s = "";
		while (lines.size() == 0 && k < 3000)
		begin
			@(posedge clock);
			k++;
		end
		if (lines.size() > 0)
			s = lines.pop_front();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cyc = cyc + 1;
		pv <= tx.valid;
		if (tx.valid && !pv && tx.data == 8'h24)
			starts.push_back(cyc);
		if (tx.valid && tx_ready)
		begin
			cur = {cur, $sformatf("%c", tx.data)};
			if (tx.data == 8'h0A)
			begin
				lines.push_back(cur);
				cur = "";
			end
		end
		if (cyc == 40000)
		begin
			n_errors++;
			summarize();
		end
	end

	initial
	begin : main
		logic [11:0] m;
		logic [95:0] id;
		logic [31:0] ph, v, u, sp, fl;
		logic [31:0] a [4];
		int k;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		check(sol === 2'h0, "status not invalid");
		apb(1, nav_fmt_pkg::OFF_STATUS, 32'h3);
		apb(0, nav_fmt_pkg::OFF_STATUS, 32'h0);
		check(rdata[1:0] === 2'h0 && err === 1'b0, "status writable");
		apb(0, 8'h40, 32'h0);
		check(err === 1'b1, "unmapped not refused");
		$display("test reset done");
		for (int j = 0; j < 8; j++)
		begin
			m = j == 0 ? 12'hFFF : j == 1 ? 12'h000 : 12'(rnd());
			id = {bcd(), bcd(), bcd()};
			ph = bcd();
			v = bcd();
			slow <= 2'(j);
			apb(1, nav_fmt_pkg::OFF_FIX, 32'(j >> 1));
			apb(1, nav_fmt_pkg::OFF_SV_MASK, 32'(m));
			apb(1, nav_fmt_pkg::OFF_SV0, id[31:0]);
			apb(1, nav_fmt_pkg::OFF_SV1, id[63:32]);
			apb(1, nav_fmt_pkg::OFF_SV2, id[95:64]);
			apb(1, nav_fmt_pkg::OFF_DOP_PH, ph);
			apb(1, nav_fmt_pkg::OFF_DOP_V, v);
			apb(1, nav_fmt_pkg::OFF_CTRL, 32'(j % 2 * 2 + 1));
			getline(got);
			check(got == gsa(j[0], 2'(j >> 1), m, id, ph, v[15:0]), "status sentence");
		end
		$display("test status sentence done");
		u = bcd();
		sp = bcd();
		fl = bcd();
		for (int i = 0; i < 4; i++)
		begin
			// yaw always negative so its sign is seen once the angle is known
			a[i] = (bcd() & 32'h000FFFFF) | (i == 3 ? 32'h80000000 : rnd() & 32'h80000000);
			apb(1, nav_fmt_pkg::OFF_ACC_X + 8'(4 * i), a[i]);
		end
		apb(1, nav_fmt_pkg::OFF_UTC, u);
		apb(1, nav_fmt_pkg::OFF_SPEED, sp);
		apb(1, nav_fmt_pkg::OFF_FLAGS, fl);
		apb(1, nav_fmt_pkg::OFF_CTRL, 32'h4);
		getline(got);
		check(got == spd(u, sp[15:0], 0, a, fl[23:0]), "motion sentence unknown angle");
		found <= 1'b1;
		@(posedge clock);
		found <= 1'b0;
		repeat (2) @(posedge clock);
		check(sol === 2'h1, "angle found ignored");
		getline(got);
		getline(got);
		check(got == spd(u, sp[15:0], 1, a, fl[23:0]), "motion sentence angle known");
		check(starts.size() > 1 && starts[$] - starts[$-1] == RATE, "motion rate");
		drv <= 1'b1;
		k = 0;
		while (sol !== 2'h2 && k < 1000)
		begin
			@(posedge clock);
			k++;
		end
		check(k >= TRAIN - 4 && k <= TRAIN + 4, "training time");
		$display("test motion sentence done");
		apb(1, nav_fmt_pkg::OFF_CTRL, 32'h0);
		strap <= 1'b1;
		drv <= 1'b0;
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		check(sol === 2'h1, "stored angle start");
		repeat (TRAIN + 50) @(posedge clock);
		check(sol === 2'h1, "trained while parked");
		$display("test stored angle done");
		summarize();
	end
endmodule // nav_sentence_formatter_test
